// ---- core/vsr_link_capture.sv ----
// Serial clock domain capture of the data line with a per-edge toggle.
`timescale 1ns/10ps
module vsr_link_capture (
  input wire logic link_scl_clk,
  input wire logic reset_n,
  input wire logic sda_in,
  output logic link_bit,
  output logic link_tog
);

  typedef struct packed {
    logic bitv;
    logic tog;
  } vsr_link_s;

  vsr_link_s q;
  vsr_link_s d;

  // Each rising serial clock samples the data line and flips the toggle.
  always_comb begin
    d = q;
    d.bitv = sda_in;
    d.tog = ~q.tog;
  end

  // The bit stays stable for a whole clock period, long after the toggle.
  always_ff @(posedge link_scl_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link_bit = q.bitv;
  assign link_tog = q.tog;

endmodule

// ---- core/vsr_pkg.sv ----
// Constants and types shared by the serial control register bank.
// Functional notes
// RULE_01: Master frames transfers with start and stop.
// RULE_02: Answer only the pin-selected seven-bit address.
// RULE_03: Write: address, sub-address, data bytes, stop.
// RULE_04: Pull data low on acknowledge clock.
// RULE_05: First byte picks register, next byte stored.
// RULE_06: Read uses repeated start, then device byte.
// RULE_07: Each register access sits between start, stop.
// RULE_08: Written registers override pin-based settings.
// RULE_09: Written values persist until rewrite or reset.
// RULE_10: Status bits report pending line-21, line-284 captions.
// RULE_11: Term A is eleven bits across two registers.
// RULE_12: Terms B and C are sixteen-bit pairs.
// RULE_13: Vertical offset is signed, one line per step.
// RULE_14: Writing vertical offset disables vertical position pins.
// RULE_15: Color bar and blank bits replace output.
// RULE_16: Format field in bits five, four, two.
// RULE_17: Bit three selects normal or swapped chroma.
// RULE_18: Software keeps standard register bits one, zero clear.
// RULE_19: Software sets PAL select bit with PAL.
// RULE_20: Zoom, overscan and freeze enables.
// RULE_21: Bits three, two choose flicker filter.
// RULE_22: Bits one, zero choose horizontal filter.
// RULE_23: Address byte 88h low pin, 8Ah high.
// RULE_24: Never acknowledge the general call address.
// RULE_25: Continuous write advances the sub-address per byte.
package vsr_pkg;

  // Register sub-addresses.
  localparam logic [7:0] VSR_SUB_STATUS = 8'h00;
  localparam logic [7:0] VSR_SUB_TERM_A_LOW = 8'h01;
  localparam logic [7:0] VSR_SUB_TERM_B_HIGH = 8'h02;
  localparam logic [7:0] VSR_SUB_TERM_B_LOW = 8'h03;
  localparam logic [7:0] VSR_SUB_TERM_C_HIGH = 8'h04;
  localparam logic [7:0] VSR_SUB_TERM_C_LOW = 8'h05;
  localparam logic [7:0] VSR_SUB_VOFFSET = 8'h07;
  localparam logic [7:0] VSR_SUB_OUT_STD = 8'h08;
  localparam logic [7:0] VSR_SUB_IN_PROC = 8'h09;
  localparam logic [7:0] VSR_SUB_PHASE_MISC = 8'h0a;

  // Slave address bytes selected by the address-select pin.
  localparam logic [7:0] VSR_SLAVE_ADDR_LO = 8'h88;
  localparam logic [7:0] VSR_SLAVE_ADDR_HI = 8'h8a;

  // Reset values of the stored registers.
  localparam logic [7:0] VSR_RST_TERM_A_LOW = 8'h00;
  localparam logic [7:0] VSR_RST_TERM_B_HIGH = 8'h00;
  localparam logic [7:0] VSR_RST_TERM_B_LOW = 8'h00;
  localparam logic [7:0] VSR_RST_TERM_C_HIGH = 8'h00;
  localparam logic [7:0] VSR_RST_TERM_C_LOW = 8'h00;
  localparam logic [7:0] VSR_RST_VOFFSET = 8'h00;
  localparam logic [7:0] VSR_RST_OUT_STD = 8'h00;
  localparam logic [7:0] VSR_RST_IN_PROC = 8'h00;
  localparam logic [7:0] VSR_RST_PHASE_MISC = 8'h00;

  // Field positions.
  localparam int VSR_STAT_LINE21 = 1;
  localparam int VSR_STAT_LINE284 = 0;
  localparam int VSR_STD_COLOR_BAR = 7;
  localparam int VSR_STD_BLANK = 6;
  localparam int VSR_STD_FMT_HI = 5;
  localparam int VSR_STD_FMT_MID = 4;
  localparam int VSR_STD_CHROMA = 3;
  localparam int VSR_STD_FMT_LO = 2;
  localparam int VSR_IPC_ZOOM = 7;
  localparam int VSR_IPC_OVERSCAN = 6;
  localparam int VSR_IPC_FREEZE = 5;
  localparam int VSR_IPC_PAL = 4;
  localparam int VSR_IPC_FLICKER_LSB = 2;
  localparam int VSR_IPC_HFILT_LSB = 0;
  localparam int VSR_SCM_PHASE_RESET = 7;
  localparam int VSR_SCM_PHASE_LSB = 4;
  localparam int VSR_SCM_TERM_A_LSB = 0;

  // Bit positions in the synchroniser vector.
  localparam int VSR_SYNC_W = 5;
  localparam int VSR_SY_SCL = 0;
  localparam int VSR_SY_SDA = 1;
  localparam int VSR_SY_ADDR = 2;
  localparam int VSR_SY_BIT = 3;
  localparam int VSR_SY_TOG = 4;

  // Bit counts of a byte and its acknowledge phases.
  localparam logic [3:0] VSR_CNT_LAST = 4'h7;
  localparam logic [3:0] VSR_CNT_ACK = 4'h8;
  localparam logic [3:0] VSR_CNT_ACK_HI = 4'h9;
  localparam logic [3:0] VSR_CNT_ACK_END = 4'ha;

  // Protocol states.
  typedef enum logic [8:0] {
    VSR_IDLE = 9'h001,
    VSR_ADDR = 9'h002,
    VSR_ADDR_ACK = 9'h004,
    VSR_SUB = 9'h008,
    VSR_SUB_ACK = 9'h010,
    VSR_WDATA = 9'h020,
    VSR_WDATA_ACK = 9'h040,
    VSR_RDATA = 9'h080,
    VSR_RACK = 9'h100
  } vsr_state_e;

endpackage

// ---- core/vsr_serial_regs.sv ----
// Serial control port slave and control register bank of the encoder.
`timescale 1ns/10ps
module vsr_serial_regs
  import vsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_sel,
  input wire logic [7:0] pin_vertical_offset,
  input wire logic [7:0] pin_output_standard,
  input wire logic [7:0] pin_input_processing,
  input wire logic caption_line21_pending,
  input wire logic caption_line284_pending,
  output logic [10:0] subcarrier_term_a,
  output logic [15:0] subcarrier_term_b,
  output logic [15:0] subcarrier_term_c,
  output logic [7:0] vertical_offset,
  output logic vpos_pins_ignored,
  output logic color_bar_en,
  output logic blank_en,
  output logic [2:0] tv_format,
  output logic chroma_order_select,
  output logic zoom_en,
  output logic overscan_en,
  output logic freeze_en,
  output logic pal_select,
  output logic [1:0] flicker_mode,
  output logic [1:0] hfilter_mode,
  output logic phase_reset_en,
  output logic [2:0] subcarrier_phase_msb
);

  typedef struct packed {
    logic [VSR_SYNC_W-1:0] s1;
    logic [VSR_SYNC_W-1:0] s2;
    logic [VSR_SYNC_W-1:0] s3;
    logic [VSR_SYNC_W-1:0] filt;
    logic pend;
    vsr_state_e st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] sub;
    logic rd;
    logic sda_oe;
    logic sda_lvl;
    logic [7:0] ta_lo;
    logic [7:0] tb_hi;
    logic [7:0] tb_lo;
    logic [7:0] tc_hi;
    logic [7:0] tc_lo;
    logic [7:0] voff;
    logic [7:0] ostd;
    logic [7:0] ipc;
    logic [7:0] scm;
    logic voff_wr;
    logic ostd_wr;
    logic ipc_wr;
    logic [10:0] term_a;
    logic [15:0] term_b;
    logic [15:0] term_c;
    logic [7:0] voff_out;
    logic [7:0] ostd_eff;
    logic [7:0] ipc_eff;
  } vsr_ctrl_s;

  vsr_ctrl_s q;
  vsr_ctrl_s d;
  logic link_bit;
  logic link_tog;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic bitv;
  logic [7:0] byte_in;
  logic [7:0] slave_addr;
  logic [7:0] rdv;

  // Register read decode; unmapped sub-addresses read as zero.
  function automatic logic [7:0] reg_read(input logic [7:0] a,
                                          input vsr_ctrl_s s,
                                          input logic cap21,
                                          input logic cap284);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      VSR_SUB_STATUS: begin
        v[VSR_STAT_LINE21] = cap21; // see RULE_10
        v[VSR_STAT_LINE284] = cap284; // see RULE_10
      end
      VSR_SUB_TERM_A_LOW: v = s.ta_lo;
      VSR_SUB_TERM_B_HIGH: v = s.tb_hi;
      VSR_SUB_TERM_B_LOW: v = s.tb_lo;
      VSR_SUB_TERM_C_HIGH: v = s.tc_hi;
      VSR_SUB_TERM_C_LOW: v = s.tc_lo;
      VSR_SUB_VOFFSET: v = s.voff;
      VSR_SUB_OUT_STD: v = s.ostd;
      VSR_SUB_IN_PROC: v = s.ipc;
      VSR_SUB_PHASE_MISC: v = s.scm;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Bits arriving from the serial clock domain.
  vsr_link_capture u_link (
    .link_scl_clk(scl_clk),
    .reset_n(reset_n),
    .sda_in(sda_in),
    .link_bit(link_bit),
    .link_tog(link_tog)
  );

  // Synchronisers, bus events, protocol engine and register updates.
  always_comb begin
    d = q;
    d.s1 = {link_tog, link_bit, addr_sel, sda_in, scl_in};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < VSR_SYNC_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.filt[i] = q.s3[i];
      end
    end
    scl_fall = q.filt[VSR_SY_SCL] & ~d.filt[VSR_SY_SCL];
    // Data edges while the clock stays high frame a transfer.
    start_ev = q.filt[VSR_SY_SCL] & d.filt[VSR_SY_SCL] &
               q.filt[VSR_SY_SDA] & ~d.filt[VSR_SY_SDA];
    stop_ev = q.filt[VSR_SY_SCL] & d.filt[VSR_SY_SCL] &
              ~q.filt[VSR_SY_SDA] & d.filt[VSR_SY_SDA];
    // A bit is consumed one cycle after its toggle so the data has settled.
    d.pend = d.filt[VSR_SY_TOG] ^ q.filt[VSR_SY_TOG];
    bitv = q.filt[VSR_SY_BIT];
    byte_in = {q.shreg[6:0], bitv};
    slave_addr = q.filt[VSR_SY_ADDR] ? VSR_SLAVE_ADDR_HI
                                     : VSR_SLAVE_ADDR_LO; // see RULE_23
    rdv = reg_read(q.sub, q, caption_line21_pending,
                   caption_line284_pending);
    if (stop_ev) begin
      d.st = VSR_IDLE; // see RULE_07
      d.sda_oe = 1'b0;
    end else if (start_ev) begin
      d.st = VSR_ADDR; // see RULE_06
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        VSR_ADDR, VSR_SUB, VSR_WDATA: begin
          if (q.pend) begin
            d.shreg = byte_in;
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == VSR_CNT_LAST) begin
              if (q.st == VSR_ADDR) begin
                // General call never equals a slave address.
                if (byte_in[7:1] == slave_addr[7:1]) begin // see RULE_02
                  d.rd = byte_in[0]; // see RULE_03
                  d.st = VSR_ADDR_ACK;
                end else begin
                  d.st = VSR_IDLE; // see RULE_24
                end
              end else if (q.st == VSR_SUB) begin
                d.sub = byte_in; // see RULE_05
                d.st = VSR_SUB_ACK;
              end else begin
                d.sub = q.sub + 8'h01; // see RULE_25
                d.st = VSR_WDATA_ACK;
                case (q.sub)
                  VSR_SUB_TERM_A_LOW: d.ta_lo = byte_in; // see RULE_11
                  VSR_SUB_TERM_B_HIGH: d.tb_hi = byte_in; // see RULE_12
                  VSR_SUB_TERM_B_LOW: d.tb_lo = byte_in;
                  VSR_SUB_TERM_C_HIGH: d.tc_hi = byte_in;
                  VSR_SUB_TERM_C_LOW: d.tc_lo = byte_in;
                  VSR_SUB_VOFFSET: begin
                    d.voff = byte_in; // see RULE_09
                    d.voff_wr = 1'b1; // see RULE_14
                  end
                  VSR_SUB_OUT_STD: begin
                    d.ostd = byte_in;
                    d.ostd_wr = 1'b1; // see RULE_08
                  end
                  VSR_SUB_IN_PROC: begin
                    d.ipc = byte_in;
                    d.ipc_wr = 1'b1; // see RULE_08
                  end
                  VSR_SUB_PHASE_MISC: d.scm = byte_in;
                  default: d.scm = q.scm;
                endcase
              end
            end
          end
        end
        VSR_ADDR_ACK, VSR_SUB_ACK, VSR_WDATA_ACK: begin
          if (scl_fall && q.cnt == VSR_CNT_ACK) begin
            d.sda_oe = 1'b1; // see RULE_04
            d.cnt = VSR_CNT_ACK_HI;
          end else if (q.pend && q.cnt == VSR_CNT_ACK_HI) begin
            d.cnt = VSR_CNT_ACK_END;
          end else if (scl_fall && q.cnt == VSR_CNT_ACK_END) begin
            d.sda_oe = 1'b0;
            d.cnt = 4'h0;
            if (q.st == VSR_ADDR_ACK && q.rd) begin
              d.st = VSR_RDATA; // see RULE_06
              d.sda_oe = ~rdv[7];
              d.shreg = {rdv[6:0], 1'b0};
              d.cnt = 4'h1;
            end else if (q.st == VSR_ADDR_ACK) begin
              d.st = VSR_SUB;
            end else begin
              d.st = VSR_WDATA;
            end
          end
        end
        VSR_RDATA: begin
          if (scl_fall) begin
            if (q.cnt == 4'h0) begin
              d.sda_oe = ~rdv[7];
              d.shreg = {rdv[6:0], 1'b0};
              d.cnt = 4'h1;
            end else if (q.cnt < VSR_CNT_ACK) begin
              d.sda_oe = ~q.shreg[7];
              d.shreg = {q.shreg[6:0], 1'b0};
              d.cnt = q.cnt + 4'h1;
            end else begin
              d.sda_oe = 1'b0;
              d.st = VSR_RACK;
            end
          end
        end
        VSR_RACK: begin
          if (q.pend) begin
            if (!bitv) begin
              d.sub = q.sub + 8'h01;
              d.cnt = 4'h0;
              d.st = VSR_RDATA;
            end else begin
              d.st = VSR_IDLE;
            end
          end
        end
        default: begin
          d.st = VSR_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
    // Registered view of the stored and effective settings.
    d.term_a = {q.scm[VSR_SCM_TERM_A_LSB +: 3], q.ta_lo}; // see RULE_11
    d.term_b = {q.tb_hi, q.tb_lo}; // see RULE_12
    d.term_c = {q.tc_hi, q.tc_lo};
    d.voff_out = q.voff_wr ? q.voff : pin_vertical_offset; // see RULE_13
    d.ostd_eff = q.ostd_wr ? q.ostd : pin_output_standard; // see RULE_08
    d.ipc_eff = q.ipc_wr ? q.ipc : pin_input_processing; // see RULE_08
  end

  // State register; the open-drain level is held low.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= VSR_IDLE;
      q.ta_lo <= VSR_RST_TERM_A_LOW;
      q.tb_hi <= VSR_RST_TERM_B_HIGH;
      q.tb_lo <= VSR_RST_TERM_B_LOW;
      q.tc_hi <= VSR_RST_TERM_C_HIGH;
      q.tc_lo <= VSR_RST_TERM_C_LOW;
      q.voff <= VSR_RST_VOFFSET;
      q.ostd <= VSR_RST_OUT_STD;
      q.ipc <= VSR_RST_IN_PROC;
      q.scm <= VSR_RST_PHASE_MISC;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign sda_out = q.sda_lvl;
  assign sda_oe = q.sda_oe;
  assign subcarrier_term_a = q.term_a;
  assign subcarrier_term_b = q.term_b;
  assign subcarrier_term_c = q.term_c;
  assign vertical_offset = q.voff_out;
  assign vpos_pins_ignored = q.voff_wr; // see RULE_14
  assign color_bar_en = q.ostd_eff[VSR_STD_COLOR_BAR]; // see RULE_15
  assign blank_en = q.ostd_eff[VSR_STD_BLANK]; // see RULE_15
  assign tv_format = {q.ostd_eff[VSR_STD_FMT_HI], q.ostd_eff[VSR_STD_FMT_MID],
                      q.ostd_eff[VSR_STD_FMT_LO]}; // see RULE_16
  assign chroma_order_select = q.ostd_eff[VSR_STD_CHROMA]; // see RULE_17
  assign zoom_en = q.ipc_eff[VSR_IPC_ZOOM]; // see RULE_20
  assign overscan_en = q.ipc_eff[VSR_IPC_OVERSCAN];
  assign freeze_en = q.ipc_eff[VSR_IPC_FREEZE];
  assign pal_select = q.ipc_eff[VSR_IPC_PAL];
  assign flicker_mode = q.ipc_eff[VSR_IPC_FLICKER_LSB +: 2]; // see RULE_21
  assign hfilter_mode = q.ipc_eff[VSR_IPC_HFILT_LSB +: 2]; // see RULE_22
  assign phase_reset_en = q.scm[VSR_SCM_PHASE_RESET];
  assign subcarrier_phase_msb = q.scm[VSR_SCM_PHASE_LSB +: 3];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Checks on the protocol engine and the register bank.
  addr_match_ack_a: assert property ( // see RULE_02
    q.pend && q.st == VSR_ADDR && q.cnt == VSR_CNT_LAST &&
    byte_in[7:1] == slave_addr[7:1] && !start_ev && !stop_ev
    |=> q.st == VSR_ADDR_ACK && q.rd == $past(bitv))
    else $error("matching address not taken");
  general_call_a: assert property ( // see RULE_24
    q.pend && q.st == VSR_ADDR && q.cnt == VSR_CNT_LAST &&
    byte_in == 8'h00 && !start_ev && !stop_ev |=> q.st == VSR_IDLE)
    else $error("general call answered");
  ack_drive_a: assert property ( // see RULE_04
    scl_fall && q.cnt == VSR_CNT_ACK && !start_ev && !stop_ev &&
    q.st inside {VSR_ADDR_ACK, VSR_SUB_ACK, VSR_WDATA_ACK}
    |=> sda_oe ##1 sda_oe)
    else $error("acknowledge not driven");
  sub_latch_a: assert property ( // see RULE_05
    q.pend && q.st == VSR_SUB && q.cnt == VSR_CNT_LAST &&
    !start_ev && !stop_ev |=> q.sub == $past(byte_in))
    else $error("sub-address not latched");
  auto_inc_a: assert property ( // see RULE_25
    q.pend && q.st == VSR_WDATA && q.cnt == VSR_CNT_LAST &&
    !start_ev && !stop_ev |=> q.sub == $past(q.sub) + 8'h01)
    else $error("sub-address not advanced");
  voff_override_a: assert property ( // see RULE_14
    q.voff_wr |=> ##1 vertical_offset == $past(q.voff) &&
    vpos_pins_ignored)
    else $error("vertical pins not overridden");
  stop_idle_a: assert property ( // see RULE_07
    stop_ev |=> q.st == VSR_IDLE && !sda_oe)
    else $error("stop not honoured");
  tv_format_a: assert property ( // see RULE_16
    q.ostd_wr && $stable(q.ostd) [*2] |->
    tv_format == {q.ostd[5], q.ostd[4], q.ostd[2]} &&
    color_bar_en == q.ostd[7] && blank_en == q.ostd[6])
    else $error("output standard decode wrong");
  persist_a: assert property ( // see RULE_09
    q.voff_wr && !(q.pend && q.st == VSR_WDATA) |=> $stable(q.voff))
    else $error("written value changed");
  status_read_a: assert property ( // see RULE_10
    q.sub == VSR_SUB_STATUS |->
    rdv[1:0] == {caption_line21_pending, caption_line284_pending})
    else $error("status flags wrong");

  write_done_c: cover property (
    q.pend && q.st == VSR_WDATA && q.cnt == VSR_CNT_LAST);
  read_load_c: cover property (
    q.st == VSR_ADDR_ACK && q.rd ##[1:1000] q.st == VSR_RDATA);
  repeat_start_c: cover property (q.st == VSR_WDATA && start_ev);

endmodule

// ---- test/vsr_i2c_master.sv ----
// Bus master model that drives the serial clock and data wires.
`timescale 1ns/10ps
module vsr_i2c_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // The clock high phase is 32 ns of a 192 ns link clock period.
  // The low phase is longer, so the slave answer is settled first.
  localparam int T_Q = 80;
  localparam int T_HI = 32;

  // The clock starts driven high and the data line released, so the pull-up holds it high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    sda_low = 1'b0;
    #T_Q scl = 1'b1;
    #T_Q sda_low = 1'b1;
    #T_Q scl = 1'b0;
    #T_Q;
  endtask

  // Stop: data rises while the clock is high, then both stay idle.
  task automatic stop_cond();
    sda_low = 1'b1;
    #T_Q scl = 1'b1;
    #T_Q sda_low = 1'b0;
    #(2 * T_Q);
  endtask

  // One clock pulse; the wire is sampled at the rising edge.
  task automatic put_bit(input logic b, output logic r);
    sda_low = ~b;
    #T_Q scl = 1'b1;
    r = sda;
    #T_HI scl = 1'b0;
    #T_Q;
  endtask

  // Sends a byte, most significant bit first, and returns the ack.
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask

  // Receives a byte, then answers with ack when more is wanted.
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(~more, r);
  endtask

  // Write transfer: address, sub-address, data bytes, all framed.
  task automatic write_seq(input logic [7:0] dev, input logic [7:0] sub,
                           input logic [7:0] d [$], output logic ack);
    logic a;
    start_cond();
    put_byte(dev, ack);
    if (ack) begin
      put_byte(sub, a);
      ack = ack & a;
      foreach (d[i]) begin
        put_byte(d[i], a);
        ack = ack & a;
      end
    end
    stop_cond();
  endtask

  // Read transfer: sub-address write, repeated start, one byte.
  task automatic read_seq(input logic [7:0] dev, input logic [7:0] sub,
                          output logic [7:0] d, output logic ack);
    logic a;
    start_cond();
    put_byte(dev, ack);
    put_byte(sub, a);
    ack = ack & a;
    start_cond();
    put_byte(dev | 8'h01, a);
    ack = ack & a;
    get_byte(1'b0, d);
    stop_cond();
  endtask
endmodule

// ---- test/vsr_serial_regs_test.sv ----
// Self-checking bench for the serial control register bank.
`timescale 1ns/10ps
module vsr_serial_regs_test;
  import vsr_pkg::*;
  logic sys_clk, reset_n, addr_sel, cap21, cap284, scl, m_sda_low;
  logic sda_out, sda_oe, vpos_pins_ignored, color_bar_en, blank_en;
  logic chroma_order_select, zoom_en, overscan_en, freeze_en, pal_select;
  logic phase_reset_en;
  logic [7:0] pin_vo, pin_std, pin_ipc, vertical_offset;
  logic [10:0] subcarrier_term_a;
  logic [15:0] subcarrier_term_b, subcarrier_term_c;
  logic [2:0] tv_format, subcarrier_phase_msb;
  logic [1:0] flicker_mode, hfilter_mode;
  int n_mismatch = 0;
  int n_compared = 0;
  // Input processing bytes; each keeps the PAL select bit set for PAL use.
  logic [7:0] ipc_vals [3] = '{8'hf2, 8'h15, 8'h59};
  int cycles = 0;
  // The data wire is open-drain with a pull-up.
  wire sda = (sda_oe ? sda_out : 1'b1) & ~m_sda_low;

  vsr_serial_regs i_vsr_serial_regs (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_clk(scl), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .pin_vertical_offset(pin_vo), .pin_output_standard(pin_std),
    .pin_input_processing(pin_ipc), .caption_line21_pending(cap21),
    .caption_line284_pending(cap284),
    .subcarrier_term_a(subcarrier_term_a),
    .subcarrier_term_b(subcarrier_term_b),
    .subcarrier_term_c(subcarrier_term_c),
    .vertical_offset(vertical_offset),
    .vpos_pins_ignored(vpos_pins_ignored), .color_bar_en(color_bar_en),
    .blank_en(blank_en), .tv_format(tv_format),
    .chroma_order_select(chroma_order_select), .zoom_en(zoom_en),
    .overscan_en(overscan_en), .freeze_en(freeze_en),
    .pal_select(pal_select), .flicker_mode(flicker_mode),
    .hfilter_mode(hfilter_mode), .phase_reset_en(phase_reset_en),
    .subcarrier_phase_msb(subcarrier_phase_msb)
  );

  vsr_i2c_master i_vsr_i2c_master (.scl(scl), .sda_low(m_sda_low),
                                   .sda(sda));

  // System clock of 8 ns.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ack %h expected %h", $time, got, exp);
    end
  endtask

  // Output standard fields against the byte that should drive them.
  task automatic chk_std(input logic [7:0] b);
    chk_val(16'({color_bar_en, blank_en, tv_format, chroma_order_select}),
            16'({b[7], b[6], b[5], b[4], b[2], b[3]}));
  endtask

  // Input processing fields against the byte that should drive them.
  task automatic chk_ipc(input logic [7:0] b);
    chk_val(16'({zoom_en, overscan_en, freeze_en, pal_select,
                 flicker_mode, hfilter_mode}), 16'(b));
  endtask

  task automatic wr(input logic [7:0] dev, input logic [7:0] sub,
                    input logic [7:0] d [$], input logic exp_ack);
    logic ack;
    i_vsr_i2c_master.write_seq(dev, sub, d, ack);
    chk_ack(ack, exp_ack);
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
    logic [7:0] d;
    logic ack;
    i_vsr_i2c_master.read_seq(VSR_SLAVE_ADDR_LO, sub, d, ack);
    chk_ack(ack, 1'b1);
    chk_val(16'(d), 16'(exp));
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (12) @(negedge sys_clk);
  endtask

  // Main sequence of transfers and expected results.
  initial begin
    logic [7:0] b;
    {addr_sel, cap21, cap284} = 3'b000;
    {pin_vo, pin_std, pin_ipc} = {8'h12, 8'hd4, 8'h3a};
    do_reset();
    chk_val(16'(vertical_offset), 16'h0012);
    chk_std(8'hd4);
    chk_ipc(8'h3a);
    wr(VSR_SLAVE_ADDR_HI, 8'h01, '{8'h55}, 1'b0);
    wr(8'h00, 8'h01, '{8'h55}, 1'b0);
    chk_val(16'(subcarrier_term_a), 16'h0000);
    @(negedge sys_clk) addr_sel = 1'b1;
    repeat (4) @(negedge sys_clk);
    wr(VSR_SLAVE_ADDR_HI, 8'h01, '{8'ha5, 8'h12, 8'h34, 8'h56, 8'h78},
       1'b1);
    wr(VSR_SLAVE_ADDR_HI, 8'h0a, '{8'hf3}, 1'b1);
    chk_val(16'(subcarrier_term_a), 16'h03a5);
    chk_val(subcarrier_term_b, 16'h1234);
    chk_val(subcarrier_term_c, 16'h5678);
    chk_val(16'({phase_reset_en, subcarrier_phase_msb}),
            16'h000f);
    @(negedge sys_clk) addr_sel = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr(VSR_SLAVE_ADDR_LO, VSR_SUB_VOFFSET, '{8'hf0}, 1'b1);
    pin_vo = 8'h21;
    repeat (4) @(negedge sys_clk);
    chk_val(16'(vertical_offset), 16'h00f0);
    chk_val(16'(vpos_pins_ignored), 16'h0001);
    // Every format code, with colour bar, blank and order varied too.
    for (int f = 0; f < 8; f++) begin
      b = {f[0], f[1], f[2], f[1], f[0], f[0], 2'b00};
      wr(VSR_SLAVE_ADDR_LO, VSR_SUB_OUT_STD, '{b}, 1'b1);
      pin_std = ~pin_std;
      repeat (4) @(negedge sys_clk);
      chk_std(b);
    end
    // Filter, zoom, overscan, freeze and PAL select settings.
    foreach (ipc_vals[i]) begin
      b = ipc_vals[i];
      wr(VSR_SLAVE_ADDR_LO, VSR_SUB_IN_PROC, '{b}, 1'b1);
      chk_ipc(b);
    end
    // One continuous write returns both registers to NTSC settings.
    wr(VSR_SLAVE_ADDR_LO, VSR_SUB_OUT_STD, '{8'h08, 8'h08},
       1'b1);
    chk_std(8'h08);
    chk_ipc(8'h08);
    {cap21, cap284} = 2'b10;
    rd(VSR_SUB_STATUS, 8'h02);
    {cap21, cap284} = 2'b01;
    wr(VSR_SLAVE_ADDR_LO, VSR_SUB_STATUS, '{8'hff}, 1'b1);
    rd(VSR_SUB_STATUS, 8'h01);
    rd(VSR_SUB_VOFFSET, 8'hf0);
    do_reset();
    chk_val(16'(vertical_offset), 16'h0021);
    chk_val(16'(vpos_pins_ignored), 16'h0000);
    chk_val(subcarrier_term_b, 16'h0000);
    give_verdict();
  end
endmodule
